// >>> bench/motor_stage_model.sv
/*
  Behavioural power stage and motor: turns the commanded current, sensor
  voltage and motion into measurements and drive state. Assumes commands change on clk.
*/
`timescale 1ns/1ps

module motor_stage_model (
  input wire logic            clk,
  input wire logic [11:0]     setCurrent,
  input wire logic [7:0]      setSensor,
  input wire logic [1:0]      setMotion,
  input wire mps_pkg::prot_t  prot,
  input wire logic            setKey,
  output mps_pkg::meas_t      meas,
  output mps_pkg::drive_t     drive,
  output logic                stopKeyPin
);
  initial meas = '{freq: 16'h1388, busVolt: 12'h3e8, default: '0};
  initial stopKeyPin = 1'h0; // key released until a scenario presses it

  // a blocked bridge carries no current; input two and pulse show junk, comm stays zero
  always @(posedge clk) begin
    meas.current <= prot.pwmBlock ? 12'h000 : setCurrent;
    meas.ainOne  <= setSensor;
    meas.ainTwo  <= ~setSensor;
    meas.pulse   <= ~meas.pulse;
    stopKeyPin   <= setKey;
    if (prot.freqLower && meas.freq != 16'h0000) begin
      meas.freq <= meas.freq - 16'h0001;
    end
    drive <= '{running: 1'h1, accel: setMotion[1], decel: setMotion[0], motorTwo: 1'h0};
  end
endmodule // motor_stage_model

// >>> bench/mps_checker_sva.sv
/*
  Port checker of the motor protection supervisor: latching of the trip
  outputs, frequency actions and AXI4-Lite answers. Assumes it is bound
  to the top module and that clkEn stays high.
*/
`timescale 1ns/1ps

module mps_checker (
  input wire logic            clk,
  input wire logic            arst_n,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  input wire mps_pkg::drive_t drive,
  input wire mps_pkg::prot_t  prot
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // trips and their consequences
  fault_blocks_pwm_a: assert property (prot.motorOverloadFault |-> prot.pwmBlock)
    else $error("overload fault without pwm block");
  // only a register write may release the block
  pwm_latch_a: assert property (prot.pwmBlock && !s_axi_awready |=> prot.pwmBlock)
    else $error("pwm block dropped without a write");
  inv_alarm_coast_a: assert property (prot.inverterOverloadAlarm |-> prot.coastStop)
    else $error("inverter alarm without coast");
  ov_alarm_coast_a: assert property (prot.overvoltageAlarm |-> prot.coastStop)
    else $error("overvoltage alarm without coast");
  // holding needs a ramp one cycle before, lowering needs a running motor
  hold_on_ramp_a: assert property (prot.freqHold |-> $past(drive.accel || drive.decel))
    else $error("frequency held outside a ramp");
  lower_when_run_a: assert property (prot.freqLower |-> $past(drive.running))
    else $error("frequency lowered while stopped");
  // bus answers
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  resp_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  read_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

  cover property (prot.motorOverloadFault);
  cover property (prot.overloadPrealarmSignal);
  cover property (prot.freqLower);
endmodule // mps_checker

bind motor_protection_supervisor mps_checker chk (.clk, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .drive, .prot);

// >>> bench/tb.sv
/*
  Testbench of the protection supervisor: register defaults, sensor trip,
  prealarm timing, current limiting, stall, stop key. Assumes the stage
  model feeds meas and the key pin.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end

module tb;
  logic            clk = 1'h0, arst_n = 1'h0;
  logic            awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]      awaddr = 8'h00, araddr = 8'h00, sensor = 8'h00;
  logic [31:0]     wdata = 32'h0, rdata;
  logic [11:0]     current = 12'h000;
  logic            key = 1'h0;
  logic [1:0]      motion = 2'h0, bresp, rresp;
  logic            awready, wready, bvalid, arready, rvalid, stopKey;
  mps_pkg::meas_t  meas;
  mps_pkg::drive_t drive;
  mps_pkg::prot_t  prot;
  int              mismatches = 0, comparisons = 0;

  always #10 clk = ~clk;

  motor_protection_supervisor #(.TICK_CYCLES(10)) dut (.clk(clk), .arst_n(arst_n),
    .clkEn(1'h1), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .meas(meas), .drive(drive), .stopKeyPin(stopKey), .prot(prot));
  motor_stage_model stage (.clk(clk), .setCurrent(current), .setSensor(sensor),
    .setMotion(motion), .prot(prot), .setKey(key), .meas(meas), .drive(drive),
    .stopKeyPin(stopKey));

  // ready is raised a cycle late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do @(posedge clk); while (awready !== 1'h1 || wready !== 1'h1);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    @(posedge clk);
    bready  <= 1'h1;
    do @(posedge clk); while (bvalid !== 1'h1);
    `CHK(bresp, 2'h0)
    bready  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    @(posedge clk);
    rready  <= 1'h1;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready  <= 1'h0;
  endtask

  task automatic defaults();
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] want [5] = '{32'h15, 32'h00640064, 32'h0578a064, 32'h02580640, 32'h32};
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), d, r);
      `CHK({r, d}, {2'h0, want[i]})
    end
    rd(8'h18, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
  endtask

  // motor one watches analog input one against 5.0 V, strictly above
  task automatic trip();
    wr(8'h04, 32'h00640032);
    wr(8'h00, 32'h00000017);
    sensor <= 8'h32;
    repeat (5) @(posedge clk);
    `CHK(prot.motorOverloadFault, 1'h0)
    sensor <= 8'h33;
    repeat (3) @(posedge clk);
    `CHK({prot.motorOverloadFault, prot.pwmBlock}, 2'h3)
    sensor <= 8'h00;
    repeat (3) @(posedge clk);
    `CHK(prot.motorOverloadFault, 1'h1)
    wr(8'h00, 32'h00000116);
    `CHK(prot.pwmBlock, 1'h0)
  endtask

  // level 100.0 %, time 0.1 s: 100 ticks of 10 clocks
  task automatic prealarm();
    wr(8'h0c, 32'h000103e8);
    current <= 12'h3e9;
    repeat (600) @(posedge clk);
    current <= 12'h3e8;
    repeat (20) @(posedge clk);
    current <= 12'h3e9;
    repeat (900) @(posedge clk);
    `CHK(prot.overloadPrealarmSignal, 1'h0)
    repeat (200) @(posedge clk);
    `CHK(prot.overloadPrealarmSignal, 1'h1)
    current <= 12'h100;
    repeat (3) @(posedge clk);
    `CHK(prot.overloadPrealarmSignal, 1'h0)
  endtask

  // action level 160 %, confirm time 50 ms = 500 clocks
  task automatic limit();
    motion  <= 2'h2;
    current <= 12'h640;
    repeat (3) @(posedge clk);
    `CHK(prot.freqHold, 1'h1)
    current <= 12'h63f;
    repeat (3) @(posedge clk);
    `CHK(prot.freqHold, 1'h0)
    motion  <= 2'h0;
    current <= 12'h640;
    repeat (3) @(posedge clk);
    `CHK({prot.freqHold, prot.freqLower}, 2'h0)
    wr(8'h00, 32'h0000001a);
    `CHK(prot.freqLower, 1'h1)
    current <= 12'h100;
    wr(8'h00, 32'h0000001e);
    `CHK(prot.freqLower, 1'h0)
    current <= 12'h640;
    repeat (300) @(posedge clk);
    `CHK(prot.freqLower, 1'h0)
    repeat (400) @(posedge clk);
    `CHK(prot.freqLower, 1'h1)
    current <= 12'h000;
    repeat (3) @(posedge clk);
    `CHK(prot.freqLower, 1'h0)
  endtask

  // stall point 100.0 %, where the model's bus already sits
  task automatic stall();
    wr(8'h08, 32'h03e8a064);
    motion <= 2'h1;
    repeat (3) @(posedge clk);
    `CHK(prot.freqHold, 1'h1)
    wr(8'h00, 32'h0000000e);
    `CHK(prot.freqHold, 1'h0)
  endtask

  // one press: four clocks down, then five clocks released
  task automatic press();
    key <= 1'h1;
    repeat (4) @(posedge clk);
    key <= 1'h0;
    repeat (5) @(posedge clk);
  endtask

  // decel limiting in mode 1 with thermal trip off; gap 2000 ticks
  task automatic keys();
    wr(8'h00, 32'h00000004);
    motion  <= 2'h1;
    current <= 12'h640;
    press();
    repeat (10000) @(posedge clk);
    press();
    `CHK(prot.inverterOverloadAlarm, 1'h0)
    repeat (21000) @(posedge clk);
    press();
    `CHK({prot.inverterOverloadAlarm, prot.coastStop}, 2'h3)
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    defaults();
    trip();
    prealarm();
    limit();
    stall();
    keys();
    conclude();
  end

  // the scenarios need about 34000 clocks
  initial begin
    #(70000 * 20);
    mismatches++;
    conclude();
  end
endmodule // tb

// >>> hw/motor_protection_supervisor.sv
/*
  Motor protection supervisor: thermal overload, sensor trip, overload
  prealarm, current limiting, over-voltage stall, AXI4-Lite registers.
  Assumes measurements and drive state come from logic on clk; the
  stop-reset key is a raw pin and is synchronised here.

*/
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mps_consts.svh"

module motor_protection_supervisor #(
  parameter int TICK_CYCLES = `CLK_HZ / `TICK_HZ
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          clkEn,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [7:0]    s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  input  wire mps_pkg::meas_t  meas,
  input  wire mps_pkg::drive_t drive,
  input  wire logic          stopKeyPin,
  output mps_pkg::prot_t     prot
);

  logic [1:0] rstSync;
  logic       rst_n;
  // release of reset is synchronised so all flops leave reset together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rstSync <= 2'b00;
    else rstSync <= {rstSync[0], 1'b1};
  end
  assign rst_n = rstSync[1];

  logic [31:0] ctrlQ, sensQ, levelQ, preQ, confQ;
  mps_pkg::ctrl_reg_t  ctrl;
  mps_pkg::sens_reg_t  sens;
  mps_pkg::level_reg_t lvl;
  mps_pkg::pre_reg_t   pre;
  mps_pkg::conf_reg_t  conf;
  assign ctrl  = mps_pkg::ctrl_reg_t'(ctrlQ);
  assign sens  = mps_pkg::sens_reg_t'(sensQ);
  assign lvl   = mps_pkg::level_reg_t'(levelQ);
  assign pre   = mps_pkg::pre_reg_t'(preQ);
  assign conf  = mps_pkg::conf_reg_t'(confQ);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r & msk;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `ADDR_CTRL || a == `ADDR_SENS || a == `ADDR_LEVEL ||
           a == `ADDR_PRE || a == `ADDR_CONF || a == `ADDR_STAT;
  endfunction

  // sensor source decode, reserved code reads as zero volts
  function automatic logic [7:0] pickSensor(input mps_pkg::src_t s, input mps_pkg::meas_t m);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      mps_pkg::SRC_AIN_ONE: v = m.ainOne;
      mps_pkg::SRC_AIN_TWO: v = m.ainTwo;
      mps_pkg::SRC_RSV:     v = 8'h00;
      mps_pkg::SRC_PULSE:   v = m.pulse;
      mps_pkg::SRC_COMM:    v = m.comm;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [11:0] pct10(input logic [7:0] p);
    return 12'(p) * `PCT_UNIT;
  endfunction

  // write address and data are taken together in one beat
  logic wrGo, rdGo;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wrGo          = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdGo          = s_axi_arvalid && s_axi_arready;

  logic faultClr;
  assign faultClr = wrGo && s_axi_awaddr == `ADDR_CTRL && s_axi_wstrb[1] &&
                    s_axi_wdata[`CTRL_CLR_BIT];

  // configuration registers, reserved bits masked off on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ  <= `CTRL_RST;
      sensQ  <= `SENS_RST;
      levelQ <= `LEVEL_RST;
      preQ   <= `PRE_RST;
      confQ  <= `CONF_RST;
    end else if (clkEn && wrGo) begin
      unique case (s_axi_awaddr)
        `ADDR_CTRL:  ctrlQ  <= merge(ctrlQ, s_axi_wdata, s_axi_wstrb, `CTRL_WMASK);
        `ADDR_SENS:  sensQ  <= merge(sensQ, s_axi_wdata, s_axi_wstrb, `SENS_WMASK);
        `ADDR_LEVEL: levelQ <= merge(levelQ, s_axi_wdata, s_axi_wstrb, `LEVEL_WMASK);
        `ADDR_PRE:   preQ   <= merge(preQ, s_axi_wdata, s_axi_wstrb, `PRE_WMASK);
        `ADDR_CONF:  confQ  <= merge(confQ, s_axi_wdata, s_axi_wstrb, `CONF_WMASK);
        default: ;
      endcase
    end
  end

  logic [31:0] status;
  logic [23:0] heatQ;
  // write response, unmapped address answers slave error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (clkEn) begin
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (clkEn) begin
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        unique case (s_axi_araddr)
          `ADDR_CTRL:  s_axi_rdata <= ctrlQ;
          `ADDR_SENS:  s_axi_rdata <= sensQ;
          `ADDR_LEVEL: s_axi_rdata <= levelQ;
          `ADDR_PRE:   s_axi_rdata <= preQ;
          `ADDR_CONF:  s_axi_rdata <= confQ;
          `ADDR_STAT:  s_axi_rdata <= status;
          default:     s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // stop-reset key: two flops, then the edge detector reads stage two
  logic [2:0] keySync;
  logic       keyPress;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) keySync <= 3'b000;
    else if (clkEn) keySync <= {keySync[1:0], stopKeyPin};
  end
  assign keyPress = keySync[1] && !keySync[2];

  // free-running millisecond tick
  logic [15:0] tickCntQ;
  logic        msTick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tickCntQ <= 16'h0000;
    else if (clkEn) tickCntQ <= msTick ? 16'h0000 : tickCntQ + 16'h0001;
  end
  assign msTick = tickCntQ == 16'(TICK_CYCLES - 1);

  // thermal threshold from the scale, derated at low speed for self-cooled motors
  logic [11:0] thermLevel, thermBase;
  logic        sensorTrip, thermTrip, overloadTrip;
  assign thermBase = pct10(lvl.thermalRelayScale);
  always_comb begin
    thermLevel = thermBase;
    if (ctrl.overloadProtMode == mps_pkg::OVL_COMMON && meas.freq < `LOW_SPEED_FRQ)
      thermLevel = thermBase - {2'b00, thermBase[11:2]};
  end
  assign sensorTrip = drive.motorTwo ?
    pickSensor(sens.motorTwoSensorSource, meas) > sens.motorTwoSensorThreshold :
    pickSensor(sens.motorOneSensorSource, meas) > sens.motorOneSensorThreshold;
  assign thermTrip = heatQ >= `THERM_TRIP;

  // heat integrates excess current each ms and cools by one when below
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) heatQ <= 24'h000000;
    else if (clkEn && msTick) begin
      if (meas.current > thermLevel) begin
        heatQ <= thermTrip ? heatQ : heatQ + 24'(meas.current - thermLevel);
      end else if (heatQ != 24'h000000) begin
        heatQ <= heatQ - 24'h000001;
      end
    end
  end

  always_comb begin
    overloadTrip = 1'b0;
    unique case (ctrl.overloadProtMode)
      mps_pkg::OVL_OFF:     overloadTrip = 1'b0;
      mps_pkg::OVL_COMMON,
      mps_pkg::OVL_VFMOTOR: overloadTrip = thermTrip;
      mps_pkg::OVL_SENSOR:  overloadTrip = sensorTrip;
    endcase
  end

  // overload prealarm: continuous-time qualification in ms
  logic [15:0] preCntQ, preTarget;
  logic        preAbove, preQd;
  assign preAbove  = meas.current > pre.prealarmLevel;
  assign preTarget = 16'(pre.prealarmTime) * `PRE_UNIT_MS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) preCntQ <= 16'h0000;
    else if (clkEn) begin
      if (!preAbove) preCntQ <= 16'h0000;
      else if (msTick && preCntQ < preTarget) preCntQ <= preCntQ + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) preQd <= 1'b0;
    else if (clkEn) preQd <= preAbove && preCntQ >= preTarget;
  end

  // current limiting decisions
  logic atLimit, ramping, steady, limitHold, limitLower, stallHold;
  logic [7:0] confCntQ;
  assign atLimit = meas.current >= pct10(lvl.currentLimitLevel);
  assign ramping = drive.accel || drive.decel;
  assign steady  = drive.running && !ramping;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) confCntQ <= 8'h00;
    else if (clkEn) begin
      if (!atLimit || ctrl.currentLimitMode != mps_pkg::CL_SLOWDOWN) confCntQ <= 8'h00;
      else if (msTick && confCntQ < conf.overcurrentConfirmTime)
        confCntQ <= confCntQ + 8'h01;
    end
  end
  always_comb begin
    limitHold  = 1'b0;
    limitLower = 1'b0;
    unique case (ctrl.currentLimitMode)
      mps_pkg::CL_OFF: ;
      mps_pkg::CL_RAMP: limitHold = atLimit && ramping;
      mps_pkg::CL_ALWAYS: begin
        limitHold  = atLimit && ramping;
        limitLower = atLimit && steady;
      end
      mps_pkg::CL_SLOWDOWN:
        limitLower = atLimit && drive.running &&
                     confCntQ >= conf.overcurrentConfirmTime;
    endcase
  end
  assign stallHold = ctrl.ovStallEnable && drive.decel &&
                     meas.busVolt >= lvl.ovStallPoint;

  // one-minute supervision of decel limiting and of stall
  logic [15:0] limMsQ, stallMsQ, keyMsQ;
  logic        decelLimiting;
  assign decelLimiting = drive.decel && (limitHold || limitLower);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) limMsQ <= 16'h0000;
    else if (clkEn) begin
      if (!decelLimiting) limMsQ <= 16'h0000;
      else if (msTick && limMsQ <= 16'(`ONE_MIN_MS)) limMsQ <= limMsQ + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stallMsQ <= 16'h0000;
    else if (clkEn) begin
      if (!stallHold) stallMsQ <= 16'h0000;
      else if (msTick && stallMsQ <= 16'(`ONE_MIN_MS)) stallMsQ <= stallMsQ + 16'h0001;
    end
  end

  // key sequence: a second press counts only after the gap has run out
  mps_pkg::key_state_t keyStateQ;
  logic keyAlarm;
  assign keyAlarm = decelLimiting && keyPress && keyStateQ == mps_pkg::KEY_ARMED &&
                    keyMsQ >= 16'(`KEY_GAP_MS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyStateQ <= mps_pkg::KEY_IDLE;
      keyMsQ    <= 16'h0000;
    end else if (clkEn) begin
      if (!decelLimiting) begin
        keyStateQ <= mps_pkg::KEY_IDLE;
        keyMsQ    <= 16'h0000;
      end else begin
        unique case (keyStateQ)
          mps_pkg::KEY_IDLE: if (keyPress) begin
            keyStateQ <= mps_pkg::KEY_ARMED;
            keyMsQ    <= 16'h0000;
          end
          mps_pkg::KEY_ARMED: begin
            if (keyPress) begin
              // early second press restarts the gap, late one fires
              keyStateQ <= keyAlarm ? mps_pkg::KEY_IDLE : mps_pkg::KEY_ARMED;
              keyMsQ    <= 16'h0000;
            end else if (msTick && keyMsQ < 16'(`KEY_GAP_MS)) begin
              keyMsQ <= keyMsQ + 16'h0001;
            end
          end
        endcase
      end
    end
  end

  // latched faults: a new trip wins over a software clear in the same cycle
  logic olFaultQ, invAlarmQ, ovAlarmQ, olSet, invSet, ovSet;
  assign olSet  = overloadTrip;
  assign invSet = keyAlarm || limMsQ > 16'(`ONE_MIN_MS);
  assign ovSet  = stallMsQ > 16'(`ONE_MIN_MS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      olFaultQ  <= 1'b0;
      invAlarmQ <= 1'b0;
      ovAlarmQ  <= 1'b0;
    end else if (clkEn) begin
      olFaultQ  <= olSet || (olFaultQ && !faultClr);
      invAlarmQ <= invSet || (invAlarmQ && !faultClr);
      ovAlarmQ  <= ovSet || (ovAlarmQ && !faultClr);
    end
  end

  // outputs from flops; stall hold masks frequency lowering, coasting gates neither frequency command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prot <= '0;
    else if (clkEn) begin
      prot.motorOverloadFault     <= olSet || (olFaultQ && !faultClr);
      prot.inverterOverloadAlarm  <= invSet || (invAlarmQ && !faultClr);
      prot.overvoltageAlarm       <= ovSet || (ovAlarmQ && !faultClr);
      prot.coastStop              <= invSet || ovSet ||
                                     ((invAlarmQ || ovAlarmQ) && !faultClr);
      prot.pwmBlock               <= olSet || invSet || ovSet ||
                                     ((olFaultQ || invAlarmQ || ovAlarmQ) && !faultClr);
      prot.overloadPrealarmSignal <= preAbove && preCntQ >= preTarget;
      prot.freqHold               <= limitHold || stallHold;
      prot.freqLower              <= limitLower && !stallHold;
    end
  end

  assign status = {heatQ[23:8], 8'h00, preQd, prot.freqLower, prot.freqHold,
                   prot.coastStop, prot.pwmBlock, ovAlarmQ, invAlarmQ, olFaultQ};

endmodule // motor_protection_supervisor

// >>> hw/mps_consts.svh
/*
  Register offsets, write masks, reset words and timing counts of the
  motor protection supervisor. Assumes inclusion by its bare name.
*/
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

// register byte addresses
`define ADDR_CTRL   8'h00
`define ADDR_SENS   8'h04
`define ADDR_LEVEL  8'h08
`define ADDR_PRE    8'h0c
`define ADDR_CONF   8'h10
`define ADDR_STAT   8'h14

// writable bits of each register
`define CTRL_WMASK  32'h0000001f
`define SENS_WMASK  32'h07ff07ff
`define LEVEL_WMASK 32'h0fffffff
`define PRE_WMASK   32'h03ff0fff
`define CONF_WMASK  32'h000000ff
`define CTRL_CLR_BIT 8

// reset words: protect common motor, limit on ramps, stall allowed,
// thresholds 10.0 V, scale 100 %, limit 160 %, stall 140 %,
// prealarm 160.0 % for 60.0 s, confirm 50 ms
`define CTRL_RST    32'h00000015
`define SENS_RST    32'h00640064
`define LEVEL_RST   32'h0578a064
`define PRE_RST     32'h02580640
`define CONF_RST    32'h00000032

// timing
`define CLK_HZ        50000000
`define TICK_HZ       1000
`define ONE_MIN_S     60
`define ONE_MIN_MS    (`ONE_MIN_S * 1000)
`define KEY_GAP_S     2
`define KEY_GAP_MS    (`KEY_GAP_S * 1000)
`define PRE_UNIT_MS   16'h0064
`define PCT_UNIT      12'h00a
`define LOW_SPEED_FRQ 16'h0bb8
`define THERM_TRIP    24'h0927c0

`endif

// >>> hw/mps_pkg.sv
/*
  Types of the motor protection supervisor: modes, register layouts and
  the measurement, drive and protection carriers. Assumes nothing.
*/
package mps_pkg;
  typedef enum logic [1:0] {OVL_OFF = 2'b00, OVL_COMMON = 2'b01,
                            OVL_VFMOTOR = 2'b10, OVL_SENSOR = 2'b11} ovl_mode_t;
  typedef enum logic [1:0] {CL_OFF = 2'b00, CL_RAMP = 2'b01,
                            CL_ALWAYS = 2'b10, CL_SLOWDOWN = 2'b11} cl_mode_t;
  typedef enum logic [2:0] {SRC_AIN_ONE = 3'b000, SRC_AIN_TWO = 3'b001,
                            SRC_RSV = 3'b010, SRC_PULSE = 3'b011,
                            SRC_COMM = 3'b100} src_t;
  typedef enum logic {KEY_IDLE = 1'b0, KEY_ARMED = 1'b1} key_state_t;
  typedef struct packed {
    logic [22:0] rsvHi; logic faultClr; logic [2:0] rsvMid;
    logic ovStallEnable; cl_mode_t currentLimitMode; ovl_mode_t overloadProtMode;
  } ctrl_reg_t;
  typedef struct packed {
    logic [4:0] rsvHi; src_t motorTwoSensorSource; logic [7:0] motorTwoSensorThreshold;
    logic [4:0] rsvLo; src_t motorOneSensorSource; logic [7:0] motorOneSensorThreshold;
  } sens_reg_t;
  typedef struct packed {
    logic [3:0] rsv; logic [11:0] ovStallPoint;
    logic [7:0] currentLimitLevel; logic [7:0] thermalRelayScale;
  } level_reg_t;
  typedef struct packed {
    logic [5:0] rsvHi; logic [9:0] prealarmTime; logic [3:0] rsvLo; logic [11:0] prealarmLevel;
  } pre_reg_t;
  typedef struct packed {
    logic [23:0] rsv; logic [7:0] overcurrentConfirmTime;
  } conf_reg_t;
  // current and bus voltage in 0.1 %, frequency in 0.01 Hz, sensors in 0.1 V
  typedef struct packed {
    logic [11:0] current; logic [15:0] freq; logic [11:0] busVolt;
    logic [7:0] ainOne; logic [7:0] ainTwo; logic [7:0] pulse; logic [7:0] comm;
  } meas_t;
  typedef struct packed {
    logic running; logic accel; logic decel; logic motorTwo;
  } drive_t;
  typedef struct packed {
    logic pwmBlock; logic motorOverloadFault; logic inverterOverloadAlarm;
    logic overvoltageAlarm; logic overloadPrealarmSignal;
    logic freqHold; logic freqLower; logic coastStop;
  } prot_t;
endpackage
